// ===== bench/exu_dma_model.sv
// dma controller stand-in that reports one access per start
`timescale 1ns/100ps
`default_nettype none
module exu_dma_model (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_start,
  input wire logic [31:0] i_addr,
  input wire logic [1:0] i_size,
  output logic o_req,
  output logic [31:0] o_addr,
  output logic [1:0] o_size
);
  // report lasts one cycle, independent of instruction flow
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_req <= 1'b0;
      o_addr <= 32'h0;
      o_size <= 2'h0;
    end else begin
      o_req <= i_start;
      if (i_start) begin
        o_addr <= i_addr;
        o_size <= i_size;
      end else begin
        // released bus: address and size invert every cycle, so the stale values come back every second cycle outside the report
        o_addr <= ~o_addr;
        o_size <= ~o_size;
      end
    end
  end
endmodule
`default_nettype wire

// ===== bench/exu_general_exception_unit_tb.sv
// self-checking bench for the general exception unit
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module exu_general_exception_unit_tb;
  import exu_pkg::*;
  logic i_clk, i_reset, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
  logic [31:0] i_paddr, i_pwdata, o_prdata, o_exc_vector, i_status_data, i_mmu_addr;
  logic i_inst_valid, i_in_slot, i_illegal_slot, i_trap, i_exc_return, i_status_load;
  logic [31:0] i_inst_pc, i_next_pc, i_branch_pc, i_branch_dest, i_dma_addr;
  logic [7:0] i_trap_imm;
  logic i_mmu_req, i_mmu_fetch, i_mmu_write, i_cpu_addr_err;
  logic i_tlb_hit, i_tlb_valid, i_tlb_prot_ok, i_tlb_dirty, i_brk_req, i_dma_req, i_irq_req;
  exu_brk_e i_brk_kind;
  logic [1:0] i_dma_size, d_size;
  logic o_exc_take, o_block_reset, o_mmu_update, o_refetch, o_irq_accept;
  logic d_start, tk, ia, rf, mu, br, rerr;
  logic [31:0] d_addr, rdv;
  int n_mismatch, n_checks, k;
  // fetch, write, hit, valid, prot_ok, dirty
  logic [5:0] mc [6] = '{6'h27, 6'h10, 6'h09, 6'h1C, 6'h0D, 6'h1E};
  logic [11:0] mx [6] = '{EXU_CODE_TLB_RD, EXU_CODE_TLB_WR, EXU_CODE_TLB_RD,
    EXU_CODE_PROT_WR, EXU_CODE_PROT_RD, EXU_CODE_INIT_WR};
  exu_general_exception_unit i_exu_general_exception_unit (.i_clk, .i_reset, .i_psel,
    .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
    .i_inst_valid, .i_inst_pc, .i_next_pc, .i_in_slot, .i_branch_pc, .i_branch_dest,
    .i_illegal_slot, .i_trap, .i_trap_imm, .i_exc_return, .i_status_load, .i_status_data, .i_mmu_req,
    .i_mmu_fetch, .i_mmu_write, .i_mmu_addr, .i_cpu_addr_err, .i_tlb_hit, .i_tlb_valid,
    .i_tlb_prot_ok, .i_tlb_dirty, .i_brk_req, .i_brk_kind, .i_dma_req, .i_dma_addr,
    .i_dma_size, .i_irq_req, .o_exc_take, .o_exc_vector, .o_block_reset, .o_mmu_update,
    .o_refetch, .o_irq_accept);
  exu_dma_model i_exu_dma_model (.i_clk, .i_reset, .i_start(d_start), .i_addr(d_addr),
    .i_size(d_size), .o_req(i_dma_req), .o_addr(i_dma_addr), .o_size(i_dma_size));
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task results;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // bounded wait: the slave answers in one cycle, but no count is assumed
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= {24'h0, a};
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge i_clk);
      if (o_pready === 1'b1) break;
    end
    if (k == 16) begin
      n_mismatch++;
      results;
    end
    rdv = o_prdata;
    rerr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rdv, e)
  endtask
  // one instruction at the judging point, then the trap, slot, break, return, status load, mmu request and irq flags drop
  task step;
    @(posedge i_clk) i_inst_valid <= 1'b1;
    @(posedge i_clk);
    i_inst_valid <= 1'b0;
    {i_trap, i_illegal_slot, i_in_slot, i_brk_req, i_exc_return, i_status_load, i_mmu_req, i_irq_req} <= 8'h0;
    #1;
    {tk, ia, rf, mu, br} = {o_exc_take, o_irq_accept, o_refetch, o_mmu_update, o_block_reset};
  endtask
  // accepted exceptions set the block bit, so status is cleared afterwards
  task exc(input logic [11:0] c, input logic [31:0] pc);
    step;
    `CHK(tk, 1'b1)
    rd(EXU_OFS_EVENT, {20'h0, c});
    rd(EXU_OFS_SAVED_PC, pc);
    wr(EXU_OFS_STATUS, 32'h0);
  endtask
  task dma(input logic [31:0] a, input logic [1:0] s);
    @(posedge i_clk);
    {d_start, d_addr, d_size} <= {1'b1, a, s};
    @(posedge i_clk);
    d_start <= 1'b0;
    repeat (2) @(posedge i_clk);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    {i_reset, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = {1'b1, 67'h0};
    {i_inst_valid, i_in_slot, i_illegal_slot, i_trap, i_exc_return, i_status_load, i_status_data} = 38'h0;
    {i_inst_pc, i_next_pc, i_branch_pc, i_branch_dest, i_trap_imm} = {32'h1000, 32'h1002, 72'h0};
    {i_mmu_req, i_mmu_fetch, i_mmu_write, i_mmu_addr, i_cpu_addr_err} = 36'h0;
    {i_tlb_hit, i_tlb_valid, i_tlb_prot_ok, i_tlb_dirty, i_brk_req, i_irq_req} = 6'h0;
    {d_start, d_addr, d_size, n_mismatch, n_checks} = 0;
    i_brk_kind = EXU_BRK_PRE;
    repeat (12) @(posedge i_clk);
    i_reset <= 1'b0;
    rd(EXU_OFS_STATUS, EXU_RST_STATUS);
    rd(EXU_OFS_CONTROL, EXU_RST_CONTROL);
    i_trap <= 1'b1;
    step;
    `CHK({tk, br}, 2'h1)
    apb(1'b0, 8'h40, 32'h0);
    `CHK(rerr, 1'b1)
    wr(EXU_OFS_VECTOR_BASE, 32'h8000_0000);
    wr(EXU_OFS_STATUS, 32'h0);
    {i_status_load, i_status_data} <= {1'b1, 32'h4000_0000};
    step;
    `CHK(rf, 1'b1)
    rd(EXU_OFS_STATUS, 32'h4000_0000);
    {i_trap, i_trap_imm} <= {1'b1, 8'hFF};
    exc(EXU_CODE_TRAP, 32'h1002);
    rd(EXU_OFS_TRAP_OPERAND, 32'h3FC);
    rd(EXU_OFS_SAVED_STATUS, 32'h4000_0000);
    rd(EXU_OFS_TARGET, 32'h8000_0100);
    `CHK(o_exc_vector, 32'h8000_0100)
    wr(EXU_OFS_SAVED_STATUS, 32'h4000_0000);
    i_exc_return <= 1'b1;
    step;
    rd(EXU_OFS_STATUS, 32'h4000_0000);
    {i_brk_req, i_brk_kind} <= {1'b1, EXU_BRK_OPERAND};
    step;
    `CHK(tk, 1'b0)
    rd(EXU_OFS_EVENT, {20'h0, EXU_CODE_TRAP});
    i_exc_return <= 1'b1;
    step;
    i_trap <= 1'b1;
    exc(EXU_CODE_TRAP, 32'h1002);
    {i_illegal_slot, i_in_slot, i_branch_pc} <= {2'h3, 32'h2000};
    exc(EXU_CODE_ILL_SLOT, 32'h2000);
    for (int b = 0; b < 4; b++) begin
      {i_brk_req, i_brk_kind, i_in_slot} <= {1'b1, exu_brk_e'(b), b == 1};
      exc(EXU_CODE_BREAK, b == 1 ? 32'h2000 : b == 0 ? 32'h1000 : 32'h1002);
    end
    i_irq_req <= 1'b1;
    step;
    `CHK(ia, 1'b1)
    {i_irq_req, i_trap} <= 2'h3;
    step;
    `CHK(ia, 1'b0)
    wr(EXU_OFS_STATUS, 32'h0);
    dma(32'h3001, EXU_SIZE_BYTE);
    dma(32'h3002, EXU_SIZE_WORD);
    step;
    `CHK(tk, 1'b0)
    dma(32'h3003, EXU_SIZE_WORD);
    {i_in_slot, i_branch_dest} <= {1'b1, 32'h4000};
    exc(EXU_CODE_DMA_ADDR, 32'h4000);
    dma(32'h3002, EXU_SIZE_LONG);
    exc(EXU_CODE_DMA_ADDR, 32'h1002);
    wr(EXU_OFS_CONTROL, 32'h1);
    for (int m = 0; m < 6; m++) begin
      {i_mmu_fetch, i_mmu_write, i_tlb_hit, i_tlb_valid, i_tlb_prot_ok, i_tlb_dirty} <= mc[m];
      {i_mmu_req, i_mmu_addr} <= {1'b1, 32'h5000_0010 + m};
      exc(mx[m], mc[m][5] ? 32'h5000_0010 + m : 32'h1000);
      `CHK(mu, 1'b1)
      rd(EXU_OFS_FAULT_ADDR, 32'h5000_0010 + m);
      rd(EXU_OFS_TARGET, mc[m][3] ? 32'h8000_0100 : 32'h8000_0400);
    end
    wr(EXU_OFS_SAVED_STATUS, EXU_RST_STATUS);
    i_exc_return <= 1'b1;
    step;
    {i_mmu_req, i_mmu_fetch, i_tlb_hit} <= 3'h6;
    exc(EXU_CODE_TLB_RD, 32'h5000_0015);
    {i_mmu_req, i_tlb_hit, i_cpu_addr_err} <= 3'h5;
    step;
    `CHK(tk, 1'b0)
    results;
  end
endmodule
`default_nettype wire

// ===== hw/exu_general_exception_unit.sv
// general exception recognition unit with APB register access
`timescale 1ns/100ps
`default_nettype none
module exu_general_exception_unit (
  input wire logic i_clk,
  input wire logic i_reset,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // instruction pipeline
  input wire logic i_inst_valid,
  input wire logic [31:0] i_inst_pc,
  input wire logic [31:0] i_next_pc,
  input wire logic i_in_slot,
  input wire logic [31:0] i_branch_pc,
  input wire logic [31:0] i_branch_dest,
  input wire logic i_illegal_slot,
  input wire logic i_trap,
  input wire logic [7:0] i_trap_imm,
  input wire logic i_exc_return,
  input wire logic i_status_load,
  input wire logic [31:0] i_status_data,
  // mmu
  input wire logic i_mmu_req,
  input wire logic i_mmu_fetch,
  input wire logic i_mmu_write,
  input wire logic [31:0] i_mmu_addr,
  input wire logic i_cpu_addr_err,
  input wire logic i_tlb_hit,
  input wire logic i_tlb_valid,
  input wire logic i_tlb_prot_ok,
  input wire logic i_tlb_dirty,
  // break controller, dma controller, interrupt request
  input wire logic i_brk_req,
  input wire exu_pkg::exu_brk_e i_brk_kind,
  input wire logic i_dma_req,
  input wire logic [31:0] i_dma_addr,
  input wire logic [1:0] i_dma_size,
  input wire logic i_irq_req,
  // results
  output logic o_exc_take,
  output logic [31:0] o_exc_vector,
  output logic o_block_reset,
  output logic o_mmu_update,
  output logic o_refetch,
  output logic o_irq_accept
);
  import exu_pkg::*;

  logic [31:0] status;
  logic [31:0] saved_status;
  logic [31:0] saved_pc;
  logic [31:0] vector_base;
  logic [11:0] event_code;
  logic [31:0] trap_operand;
  logic [31:0] fault_addr;
  logic [31:0] control;
  logic [31:0] old_status;
  logic ret_slot;
  logic dma_pend;

  // ----------------------------------------------------------------
  // event detection
  // ----------------------------------------------------------------
  logic dma_misaligned;
  logic mmu_chk, tlb_miss, tlb_inval, tlb_prot, init_wr, mmu_fault;
  logic brk_ok, brk_pre, brk_done, fetch_block;

  assign dma_misaligned = i_dma_req && (((i_dma_size == EXU_SIZE_WORD) && i_dma_addr[0]) ||
                          ((i_dma_size == EXU_SIZE_LONG) && (i_dma_addr[1:0] != 2'h0)));
  // a cpu address error masks every mmu check of the same access
  assign mmu_chk = control[EXU_CTRL_AT] && i_inst_valid && i_mmu_req && !i_cpu_addr_err;
  assign tlb_miss = mmu_chk && !i_tlb_hit;
  assign tlb_inval = mmu_chk && i_tlb_hit && !i_tlb_valid;
  assign tlb_prot = mmu_chk && i_tlb_hit && i_tlb_valid && !i_tlb_prot_ok;
  assign init_wr = mmu_chk && i_tlb_hit && i_tlb_valid && i_tlb_prot_ok && i_mmu_write && !i_tlb_dirty;
  assign mmu_fault = tlb_miss || tlb_inval || tlb_prot || init_wr;
  // breaks are dropped under the block bit and in the return slot
  assign brk_ok = i_inst_valid && i_brk_req && !ret_slot && !status[EXU_STATUS_BLOCK];
  assign brk_pre = brk_ok && (i_brk_kind == EXU_BRK_PRE);
  assign brk_done = brk_ok && (i_brk_kind != EXU_BRK_PRE);
  // fetches in the return slot were issued under the status before restore
  assign fetch_block = ret_slot ? old_status[EXU_STATUS_BLOCK] : status[EXU_STATUS_BLOCK];

  function automatic logic [11:0] mmu_code(input logic miss_or_inv, input logic prot, input logic wr);
    logic [11:0] c;
    c = EXU_CODE_INIT_WR;
    if (miss_or_inv) begin
      c = wr ? EXU_CODE_TLB_WR : EXU_CODE_TLB_RD;
    end else if (prot) begin
      c = wr ? EXU_CODE_PROT_WR : EXU_CODE_PROT_RD;
    end
    return c;
  endfunction

  // ----------------------------------------------------------------
  // priority selection
  // ----------------------------------------------------------------
  logic fire, sel_miss, sel_mmu, sel_trap, sel_dma, eff_block;
  logic [11:0] next_code;
  logic [31:0] next_save;

  always_comb begin
    fire = 1'b1;
    sel_miss = 1'b0;
    sel_mmu = 1'b0;
    sel_trap = 1'b0;
    sel_dma = 1'b0;
    eff_block = status[EXU_STATUS_BLOCK];
    next_code = EXU_CODE_POWER_ON;
    next_save = i_inst_pc;
    if (brk_pre) begin
      next_code = EXU_CODE_BREAK;
      next_save = i_in_slot ? i_branch_pc : i_inst_pc;
    end else if (mmu_fault && i_mmu_fetch) begin
      sel_mmu = 1'b1;
      sel_miss = tlb_miss;
      eff_block = fetch_block;
      next_code = mmu_code(tlb_miss || tlb_inval, tlb_prot, 1'b0);
      next_save = i_mmu_addr;
    end else if (i_inst_valid && i_illegal_slot) begin
      next_code = EXU_CODE_ILL_SLOT;
      next_save = i_branch_pc;
    end else if (mmu_fault) begin
      sel_mmu = 1'b1;
      sel_miss = tlb_miss;
      next_code = mmu_code(tlb_miss || tlb_inval, tlb_prot, i_mmu_write);
      next_save = i_in_slot ? i_branch_pc : i_inst_pc;
    end else if (i_inst_valid && i_trap) begin
      sel_trap = 1'b1;
      next_code = EXU_CODE_TRAP;
      next_save = i_next_pc;
    end else if (brk_done) begin
      next_code = EXU_CODE_BREAK;
      next_save = i_in_slot ? i_branch_pc : i_next_pc;
    end else if (i_inst_valid && dma_pend && !status[EXU_STATUS_BLOCK]) begin
      sel_dma = 1'b1;
      next_code = EXU_CODE_DMA_ADDR;
      next_save = i_in_slot ? i_branch_dest : i_next_pc;
    end else begin
      fire = 1'b0;
    end
  end

  logic take, block_hit;
  assign take = fire && !eff_block;
  assign block_hit = fire && eff_block;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic setup, wr_en;
  logic mapped;
  logic [31:0] rd_mux;
  assign setup = i_psel && !i_penable;
  assign wr_en = i_psel && i_penable && o_pready && i_pwrite && !o_pslverr;

  always_comb begin
    mapped = 1'b1;
    rd_mux = EXU_RST_ZERO;
    case (i_paddr[7:0])
      EXU_OFS_STATUS: rd_mux = status;
      EXU_OFS_SAVED_STATUS: rd_mux = saved_status;
      EXU_OFS_SAVED_PC: rd_mux = saved_pc;
      EXU_OFS_VECTOR_BASE: rd_mux = vector_base;
      EXU_OFS_EVENT: rd_mux = {20'h00000, event_code};
      EXU_OFS_TRAP_OPERAND: rd_mux = trap_operand;
      EXU_OFS_FAULT_ADDR: rd_mux = fault_addr;
      EXU_OFS_CONTROL: rd_mux = control;
      EXU_OFS_TARGET: rd_mux = o_exc_vector;
      default: mapped = 1'b0;
    endcase
    if (i_paddr[31:8] != 24'h000000) begin
      mapped = 1'b0;
    end
  end

  // ready one cycle after setup: every transfer has one access cycle
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= EXU_RST_ZERO;
    end else begin
      o_pready <= setup;
      o_pslverr <= setup && !mapped;
      if (setup) begin
        o_prdata <= (!i_pwrite && mapped) ? rd_mux : EXU_RST_ZERO;
      end
    end
  end

  // ----------------------------------------------------------------
  // status and saved state
  // ----------------------------------------------------------------
  logic [31:0] next_status;
  always_comb begin
    next_status = status;
    if (wr_en && (i_paddr[7:0] == EXU_OFS_STATUS)) begin
      next_status = i_pwdata;
    end
    if (i_inst_valid && i_exc_return) begin
      next_status = saved_status;
    end
    if (i_inst_valid && i_status_load) begin
      next_status = i_status_data;
    end
    if (take) begin
      next_status[EXU_STATUS_MODE] = 1'b1;
      next_status[EXU_STATUS_BLOCK] = 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      status <= EXU_RST_STATUS;
    end else begin
      status <= next_status;
    end
  end

  // hardware saving wins over a software write in the same cycle
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      saved_status <= EXU_RST_ZERO;
      saved_pc <= EXU_RST_ZERO;
    end else if (take) begin
      saved_status <= status;
      saved_pc <= next_save;
    end else if (wr_en && (i_paddr[7:0] == EXU_OFS_SAVED_STATUS)) begin
      saved_status <= i_pwdata;
    end else if (wr_en && (i_paddr[7:0] == EXU_OFS_SAVED_PC)) begin
      saved_pc <= i_pwdata;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      vector_base <= EXU_RST_ZERO;
      control <= EXU_RST_CONTROL;
    end else if (wr_en && (i_paddr[7:0] == EXU_OFS_VECTOR_BASE)) begin
      vector_base <= i_pwdata;
    end else if (wr_en && (i_paddr[7:0] == EXU_OFS_CONTROL)) begin
      control <= {31'h00000000, i_pwdata[EXU_CTRL_AT]};
    end
  end

  // ----------------------------------------------------------------
  // event, trap operand and fault address
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      event_code <= EXU_CODE_POWER_ON;
      trap_operand <= EXU_RST_ZERO;
      fault_addr <= EXU_RST_ZERO;
    end else if (take) begin
      event_code <= next_code;
      if (sel_trap) begin
        trap_operand <= {22'h000000, i_trap_imm, 2'h0};
      end
      if (sel_mmu) begin
        fault_addr <= i_mmu_addr;
      end
    end
  end

  // ----------------------------------------------------------------
  // return slot tracking and dma error pending
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ret_slot <= 1'b0;
      old_status <= EXU_RST_STATUS;
    end else if (i_inst_valid) begin
      ret_slot <= i_exc_return && !take;
      if (i_exc_return) begin
        old_status <= status;
      end
    end
  end

  // a new error arriving as the old one is taken stays pending
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      dma_pend <= 1'b0;
    end else if (dma_misaligned) begin
      dma_pend <= 1'b1;
    end else if (take && sel_dma) begin
      dma_pend <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // result outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_exc_take <= 1'b0;
      o_exc_vector <= EXU_RST_ZERO;
      o_block_reset <= 1'b0;
      o_mmu_update <= 1'b0;
      o_refetch <= 1'b0;
      o_irq_accept <= 1'b0;
    end else begin
      o_exc_take <= take;
      if (take) begin
        o_exc_vector <= vector_base + (sel_miss ? EXU_VEC_TLB_MISS : EXU_VEC_GENERAL);
      end
      o_block_reset <= block_hit;
      o_mmu_update <= take && sel_mmu;
      o_refetch <= i_inst_valid && i_status_load && !take &&
                   ((i_status_data[EXU_STATUS_MODE] != status[EXU_STATUS_MODE]) ||
                    (i_status_data[EXU_STATUS_BLOCK] != status[EXU_STATUS_BLOCK]));
      o_irq_accept <= i_inst_valid && i_irq_req && !fire && !status[EXU_STATUS_BLOCK];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_trap_alone;
    i_inst_valid && i_trap && !brk_pre && !mmu_fault && !i_illegal_slot && !status[EXU_STATUS_BLOCK];
  endsequence

  sequence s_trap_saved;
    o_exc_take && event_code == EXU_CODE_TRAP && trap_operand[9:2] == $past(i_trap_imm);
  endsequence

  a_trap_effects: assert property (@(posedge i_clk) disable iff (i_reset)
    s_trap_alone |=> s_trap_saved and (saved_pc == $past(i_next_pc)))
    else $error("trap code, operand or save address wrong");

  a_slot_save: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_inst_valid && i_illegal_slot && !brk_pre && !(mmu_fault && i_mmu_fetch) && !status[EXU_STATUS_BLOCK])
    |=> (event_code == EXU_CODE_ILL_SLOT) && (saved_pc == $past(i_branch_pc)))
    else $error("illegal slot exception saved wrong");

  a_miss_vector: assert property (@(posedge i_clk) disable iff (i_reset)
    (take && sel_miss) |=> o_exc_vector == $past(vector_base) + EXU_VEC_TLB_MISS)
    else $error("tlb miss vector wrong");

  a_general_vector: assert property (@(posedge i_clk) disable iff (i_reset)
    (take && !sel_miss) |=> o_exc_vector == $past(vector_base) + EXU_VEC_GENERAL)
    else $error("general vector wrong");

  a_fault_addr: assert property (@(posedge i_clk) disable iff (i_reset)
    (take && sel_mmu) |=> o_mmu_update && fault_addr == $past(i_mmu_addr))
    else $error("fault address not latched");

  a_addr_err_first: assert property (@(posedge i_clk) disable iff (i_reset)
    i_cpu_addr_err |-> !mmu_fault)
    else $error("mmu fault raised over cpu address error");

  a_dma_kept: assert property (@(posedge i_clk) disable iff (i_reset)
    dma_misaligned |=> dma_pend ##0 (!o_exc_take || event_code != EXU_CODE_DMA_ADDR || dma_pend))
    else $error("dma address error lost");

  a_slot_no_break: assert property (@(posedge i_clk) disable iff (i_reset)
    (ret_slot && i_brk_req) |-> !brk_pre && !brk_done)
    else $error("break accepted in return slot");

  a_irq_yield: assert property (@(posedge i_clk) disable iff (i_reset)
    fire |=> !o_irq_accept)
    else $error("interrupt accepted over general exception");

  a_status_saved: assert property (@(posedge i_clk) disable iff (i_reset)
    take |=> saved_status == $past(status) && status[EXU_STATUS_BLOCK] && status[EXU_STATUS_MODE] && o_exc_take)
    else $error("status not saved on exception");

  a_init_write: assert property (@(posedge i_clk) disable iff (i_reset)
    (take && sel_mmu && init_wr && !i_mmu_fetch) |=> event_code == EXU_CODE_INIT_WR)
    else $error("initial page write code wrong");

endmodule
`default_nettype wire

// ===== inc/exu_pkg.sv
// constants shared by the general exception unit
package exu_pkg;
  // ----------------------------------------------------------------
  // exception codes
  // ----------------------------------------------------------------
  localparam logic [11:0] EXU_CODE_POWER_ON = 12'h000;
  localparam logic [11:0] EXU_CODE_ILL_SLOT = 12'h1A0;
  localparam logic [11:0] EXU_CODE_TRAP = 12'h160;
  localparam logic [11:0] EXU_CODE_BREAK = 12'h1E0;
  localparam logic [11:0] EXU_CODE_DMA_ADDR = 12'h5C0;
  localparam logic [11:0] EXU_CODE_TLB_RD = 12'h040;
  localparam logic [11:0] EXU_CODE_TLB_WR = 12'h060;
  localparam logic [11:0] EXU_CODE_PROT_RD = 12'h0A0;
  localparam logic [11:0] EXU_CODE_PROT_WR = 12'h0C0;
  localparam logic [11:0] EXU_CODE_INIT_WR = 12'h080;
  // ----------------------------------------------------------------
  // vector offsets from the vector base
  // ----------------------------------------------------------------
  localparam logic [31:0] EXU_VEC_GENERAL = 32'h0000_0100;
  localparam logic [31:0] EXU_VEC_TLB_MISS = 32'h0000_0400;
  // ----------------------------------------------------------------
  // register byte offsets on the APB
  // ----------------------------------------------------------------
  localparam logic [7:0] EXU_OFS_STATUS = 8'h00;
  localparam logic [7:0] EXU_OFS_SAVED_STATUS = 8'h04;
  localparam logic [7:0] EXU_OFS_SAVED_PC = 8'h08;
  localparam logic [7:0] EXU_OFS_VECTOR_BASE = 8'h0C;
  localparam logic [7:0] EXU_OFS_EVENT = 8'h10;
  localparam logic [7:0] EXU_OFS_TRAP_OPERAND = 8'h14;
  localparam logic [7:0] EXU_OFS_FAULT_ADDR = 8'h18;
  localparam logic [7:0] EXU_OFS_CONTROL = 8'h1C;
  localparam logic [7:0] EXU_OFS_TARGET = 8'h20;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int EXU_STATUS_MODE = 30;
  localparam int EXU_STATUS_BLOCK = 28;
  localparam int EXU_CTRL_AT = 0;
  localparam int EXU_TRAP_OPERAND_LSB = 2;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] EXU_RST_STATUS = 32'h5000_0000;
  localparam logic [31:0] EXU_RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] EXU_RST_CONTROL = 32'h0000_0000;
  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EXU_BRK_PRE = 2'h0,
    EXU_BRK_OPERAND = 2'h1,
    EXU_BRK_DATA = 2'h2,
    EXU_BRK_IBUS = 2'h3
  } exu_brk_e;
  localparam logic [1:0] EXU_SIZE_BYTE = 2'h0;
  localparam logic [1:0] EXU_SIZE_WORD = 2'h1;
  localparam logic [1:0] EXU_SIZE_LONG = 2'h2;
endpackage
